// file: include/sot_params.svh
`ifndef SOT_PARAMS_SVH
`define SOT_PARAMS_SVH
// Contract
// RL1: write with eight-beat burst holds termination 6 clocks (1ck) or 7 (2ck).
// RL2: no write or chopped write holds termination 4 clocks (1ck) or 5 (2ck).
// RL3: first strobe rising edge at least 40 clocks after leveling entry.
// RL4: strobe driven no earlier than 25 clocks after leveling entry.
// RL5: device starts internal write 4 cycles after latency, 2 if chop fixed.
// RL6: with parity on and delay loop off, refresh wait grows by parity latency.
// RL7: command/address latency at least max of 3 clocks or 3.748 ns per period.
// RL8: below 1600 MT/s the 1600 grade timing applies.
// RL9: time figures become cycle counts by dividing by period and rounding up.
// RL10: spread accesses over rows; repeated hits on one row are flagged.
// RL11: device drives read strobe one cycle earlier in two-clock preamble.
// RL12: gear-down never enabled below 2666 MT/s.
// RL13: in leveling the device returns the clock sampled at each strobe edge.

// ==================================================
// clock
`define SOT_CLK_PS            40000
// ==================================================
// termination hold lengths in clocks
`define SOT_TERM_LONG_1CK     6
`define SOT_TERM_LONG_2CK     7
`define SOT_TERM_SHORT_1CK    4
`define SOT_TERM_SHORT_2CK    5
// ==================================================
// write leveling entry delays in clocks
`define SOT_LVL_FIRST_STROBE  40
`define SOT_LVL_STROBE_DRIVE  25
// ==================================================
// command/address latency
`define SOT_CAL_MIN_CK        3
`define SOT_CAL_TIME_PS       3748
// ==================================================
// data-rate thresholds in MT/s
`define SOT_RATE_FLOOR        1600
`define SOT_GEAR_MIN_RATE     2666
// ==================================================
// same-row access count that raises the warning
`define SOT_ROW_HOT_LIMIT     8
`endif

// file: include/sot_pkg.sv
`include "sot_params.svh"
package sot_pkg;
    // ==================================================
    // user operations
    typedef enum logic [2:0] {
        OP_WRITE, OP_TERM, OP_REFRESH, OP_LVL_ON, OP_LVL_OFF, OP_STROBE,
        OP_GEAR
    } sot_op_t;
    // commands placed on the device
    typedef enum logic [2:0] {
        DC_NOP, DC_WRITE, DC_REF, DC_MRS_LVL_ON, DC_MRS_LVL_OFF
    } sot_dcmd_t;
    typedef enum logic [1:0] {ST_IDLE, ST_TERM, ST_REF, ST_LVL} sot_state_t;

    // time in ps to whole clocks, rounded up, never below one
    function automatic int ps_to_ck(input int t_ps);
        int n;
        n = (t_ps + `SOT_CLK_PS - 1) / `SOT_CLK_PS;
        return (n < 1) ? 1 : n;
    endfunction

    // larger of two counts
    function automatic int max_ck(input int a, input int b);
        return (a > b) ? a : b;
    endfunction
endpackage

// file: include/sot_tmr_if.sv
interface sot_tmr_if;
    logic       load;
    logic [8:0] load_val;
    logic       expired;
    modport ctl (output load, output load_val, input expired);
    modport tmr (input load, input load_val, output expired);
endinterface

// file: design/sot_timer.sv
module sot_timer (
    input wire logic sys_clk,
    input wire logic nrst,
    sot_tmr_if.tmr   tif
);
    import sot_pkg::*;
    logic [8:0] count_reg;
    logic [8:0] count_next;

    // ==================================================
    // down counter, reload wins over decrement
    always_comb begin
        count_next = count_reg;
        if (tif.load) begin
            count_next = tif.load_val;
        end else if (count_reg != 9'h000) begin
            count_next = count_reg - 9'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 9'h000;
        end else begin
            count_reg <= count_next;
        end
    end

    assign tif.expired = (count_reg == 9'h000);
endmodule

// file: design/sot_ctrl.sv
module sot_ctrl (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire sot_pkg::sot_op_t  cmd_op,
    input  wire logic              cmd_chop,
    input  wire logic [15:0]       cmd_row,
    input  wire logic              pre_2ck,
    input  wire logic              parity_en,
    input  wire logic              dll_off,
    input  wire logic [3:0]        parity_latency,
    input  wire logic [7:0]        refresh_cycle_time,
    input  wire logic [3:0]        cal_request,
    input  wire logic [11:0]       data_rate,
    output sot_pkg::sot_dcmd_t     ddr_cmd,
    output logic                   ddr_cmd_valid,
    output logic                   ddr_odt,
    output logic                   dqs_out,
    output logic                   dqs_oe,
    input  wire logic              dq_in,
    output logic                   level_result,
    output logic                   level_valid,
    output logic [3:0]             cal_setting,
    output logic [11:0]            applied_rate,
    output logic                   gear_en,
    output logic                   gear_refused,
    output logic                   row_hot
);
    import sot_pkg::*;

    localparam int CAL_MIN = max_ck(`SOT_CAL_MIN_CK,
                                    ps_to_ck(`SOT_CAL_TIME_PS));
    localparam logic [7:0] FIRST_STROBE = 8'(`SOT_LVL_FIRST_STROBE);
    localparam logic [7:0] STROBE_DRIVE = 8'(`SOT_LVL_STROBE_DRIVE);

    sot_tmr_if tif ();
    sot_timer u_timer (.sys_clk(sys_clk), .nrst(nrst), .tif(tif));

    sot_state_t state_reg, state_next;
    sot_dcmd_t  dcmd_reg, dcmd_next;
    logic       dval_reg, dval_next;
    logic       odt_reg, odt_next;
    logic       dqs_reg, dqs_next;
    logic       oe_reg, oe_next;
    logic [7:0] age_reg, age_next;
    logic       samp_reg, samp_next;
    logic       lres_reg, lres_next;
    logic       lval_reg, lval_next;
    logic [3:0] hold_reg, hold_next;
    logic       gear_reg, gear_next;
    logic       gref_reg, gref_next;
    logic [15:0] row_reg, row_next;
    logic [3:0] hits_reg, hits_next;
    logic       take;

    assign cmd_ready = (state_reg == ST_IDLE) ||
                       ((state_reg == ST_LVL) &&
                        (cmd_op == OP_STROBE || cmd_op == OP_LVL_OFF));
    assign take = cmd_valid && cmd_ready;

    // ==================================================
    // main sequencer
    always_comb begin
        state_next   = state_reg;
        dcmd_next    = DC_NOP;
        dval_next    = 1'b0;
        odt_next     = odt_reg;
        dqs_next     = 1'b0;
        oe_next      = oe_reg;
        age_next     = age_reg;
        samp_next    = 1'b0;
        lres_next    = lres_reg;
        lval_next    = 1'b0;
        hold_next    = hold_reg;
        gear_next    = 1'b0;
        gref_next    = 1'b0;
        row_next     = row_reg;
        hits_next    = hits_reg;
        tif.load     = 1'b0;
        tif.load_val = 9'h000;
        unique case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    unique case (cmd_op)
                        OP_WRITE, OP_TERM: begin
                            if (cmd_op == OP_WRITE && !cmd_chop) begin
                                hold_next = pre_2ck ? 4'(`SOT_TERM_LONG_2CK)
                                    : 4'(`SOT_TERM_LONG_1CK); // [RL1]
                            end else begin
                                hold_next = pre_2ck ? 4'(`SOT_TERM_SHORT_2CK)
                                    : 4'(`SOT_TERM_SHORT_1CK); // [RL2]
                            end
                            tif.load     = 1'b1;
                            tif.load_val = 9'(hold_next) - 9'h001;
                            odt_next     = 1'b1;
                            state_next   = ST_TERM;
                            if (cmd_op == OP_WRITE) begin
                                dcmd_next = DC_WRITE;
                                dval_next = 1'b1;
                                // count back-to-back writes to one row [RL10]
                                row_next  = cmd_row;
                                if (cmd_row == row_reg) begin
                                    if (hits_reg != 4'hf) begin
                                        hits_next = hits_reg + 4'h1;
                                    end
                                end else begin
                                    hits_next = 4'h1;
                                end
                            end
                        end
                        OP_REFRESH: begin
                            tif.load     = 1'b1;
                            tif.load_val = {1'b0, refresh_cycle_time}
                                - 9'h001;
                            if (parity_en && dll_off) begin
                                tif.load_val = {1'b0, refresh_cycle_time}
                                    + {5'h00, parity_latency}
                                    - 9'h001; // [RL6]
                            end
                            dcmd_next  = DC_REF;
                            dval_next  = 1'b1;
                            state_next = ST_REF;
                        end
                        OP_LVL_ON: begin
                            dcmd_next  = DC_MRS_LVL_ON;
                            dval_next  = 1'b1;
                            age_next   = 8'h00;
                            state_next = ST_LVL;
                        end
                        OP_GEAR: begin
                            // gear-down only at or above its floor [RL12]
                            if (data_rate < 12'(`SOT_GEAR_MIN_RATE)) begin
                                gref_next = 1'b1;
                            end else begin
                                gear_next = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_TERM: begin
                if (tif.expired) begin
                    odt_next   = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            ST_REF: begin
                if (tif.expired) begin
                    state_next = ST_IDLE;
                end
            end
            ST_LVL: begin
                if (age_reg != 8'hff) begin
                    age_next = age_reg + 8'h01;
                end
                if (age_reg >= STROBE_DRIVE - 8'h01) begin
                    oe_next = 1'b1; // [RL4]
                end
                if (take && cmd_op == OP_STROBE &&
                    age_reg >= FIRST_STROBE && !dqs_reg) begin
                    dqs_next = 1'b1; // [RL3]
                end
                if (take && cmd_op == OP_LVL_OFF) begin
                    dcmd_next  = DC_MRS_LVL_OFF;
                    dval_next  = 1'b1;
                    oe_next    = 1'b0;
                    dqs_next   = 1'b0;
                    state_next = ST_IDLE;
                end
            end
        endcase
        // feedback sampled one cycle after each strobe rising edge [RL13]
        samp_next = dqs_reg;
        if (samp_reg) begin
            lres_next = dq_in;
            lval_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            dcmd_reg  <= DC_NOP;
            dval_reg  <= 1'b0;
            odt_reg   <= 1'b0;
            dqs_reg   <= 1'b0;
            oe_reg    <= 1'b0;
            age_reg   <= 8'h00;
            samp_reg  <= 1'b0;
            lres_reg  <= 1'b0;
            lval_reg  <= 1'b0;
            hold_reg  <= 4'h0;
            gear_reg  <= 1'b0;
            gref_reg  <= 1'b0;
            row_reg   <= 16'h0000;
            hits_reg  <= 4'h0;
        end else begin
            state_reg <= state_next;
            dcmd_reg  <= dcmd_next;
            dval_reg  <= dval_next;
            odt_reg   <= odt_next;
            dqs_reg   <= dqs_next;
            oe_reg    <= oe_next;
            age_reg   <= age_next;
            samp_reg  <= samp_next;
            lres_reg  <= lres_next;
            lval_reg  <= lval_next;
            hold_reg  <= hold_next;
            gear_reg  <= gear_next;
            gref_reg  <= gref_next;
            row_reg   <= row_next;
            hits_reg  <= hits_next;
        end
    end

    // ==================================================
    // latency clamp and applied timing grade
    logic [3:0]  cal_reg, cal_next;
    logic [11:0] rate_reg, rate_next;
    always_comb begin
        cal_next = (cal_request < 4'(CAL_MIN)) ? 4'(CAL_MIN)
            : cal_request; // [RL7] [RL9]
        rate_next = (data_rate < 12'(`SOT_RATE_FLOOR)) ?
            12'(`SOT_RATE_FLOOR) : data_rate; // [RL8]
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cal_reg  <= 4'(`SOT_CAL_MIN_CK);
            rate_reg <= 12'(`SOT_RATE_FLOOR);
        end else begin
            cal_reg  <= cal_next;
            rate_reg <= rate_next;
        end
    end

    assign ddr_cmd       = dcmd_reg;
    assign ddr_cmd_valid = dval_reg;
    assign ddr_odt       = odt_reg;
    assign dqs_out       = dqs_reg;
    assign dqs_oe        = oe_reg;
    assign level_result  = lres_reg;
    assign level_valid   = lval_reg;
    assign cal_setting   = cal_reg;
    assign applied_rate  = rate_reg;
    assign gear_en       = gear_reg;
    assign gear_refused  = gref_reg;
    assign row_hot       = (hits_reg >= 4'(`SOT_ROW_HOT_LIMIT)); // [RL10]

    // ==================================================
    // checks
    logic [9:0] gap_reg;
    logic [9:0] need_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gap_reg  <= 10'h3ff;
            need_reg <= 10'h000;
        end else if (dval_reg && dcmd_reg == DC_REF) begin
            gap_reg  <= 10'h001;
            need_reg <= 10'(refresh_cycle_time) +
                ((parity_en && dll_off) ? 10'(parity_latency) : 10'h000);
        end else if (gap_reg != 10'h3ff) begin
            gap_reg <= gap_reg + 10'h001;
        end
    end

    a_term_long_1ck: assert property (@(posedge sys_clk) // [RL1]
        disable iff (!nrst) $rose(odt_reg) && hold_reg == 4'h6 |->
        odt_reg [*6] ##1 !odt_reg) else $error("long hold 1ck wrong");
    a_term_long_2ck: assert property (@(posedge sys_clk) // [RL1]
        disable iff (!nrst) $rose(odt_reg) && hold_reg == 4'h7 |->
        odt_reg [*7]) else $error("long hold 2ck short");
    a_term_short_1ck: assert property (@(posedge sys_clk) // [RL2]
        disable iff (!nrst) $rose(odt_reg) && hold_reg == 4'h4 |->
        odt_reg [*4]) else $error("short hold 1ck short");
    a_term_short_2ck: assert property (@(posedge sys_clk) // [RL2]
        disable iff (!nrst) $rose(odt_reg) && hold_reg == 4'h5 |->
        odt_reg [*5]) else $error("short hold 2ck short");
    a_first_strobe: assert property (@(posedge sys_clk) // [RL3]
        disable iff (!nrst) $rose(dqs_reg) |-> age_reg >= FIRST_STROBE)
        else $error("strobe too early");
    a_strobe_drive: assert property (@(posedge sys_clk) // [RL4]
        disable iff (!nrst) $rose(oe_reg) |-> age_reg >= STROBE_DRIVE &&
        $past(state_reg) == ST_LVL) else $error("strobe driven too early");
    a_refresh_gap: assert property (@(posedge sys_clk) // [RL6]
        disable iff (!nrst) dval_reg && gap_reg != 10'h3ff |->
        gap_reg >= need_reg) else $error("command inside refresh wait");
    a_cal_floor: assert property (@(posedge sys_clk) // [RL7]
        disable iff (!nrst) cal_reg >= 4'(CAL_MIN))
        else $error("latency below floor");
    a_rate_floor: assert property (@(posedge sys_clk) // [RL8]
        disable iff (!nrst) $past(data_rate) < 12'(`SOT_RATE_FLOOR) |->
        rate_reg == 12'(`SOT_RATE_FLOOR)) else $error("grade not floored");
    a_gear_block: assert property (@(posedge sys_clk) // [RL12]
        disable iff (!nrst) gear_reg |-> $past(data_rate) >=
        12'(`SOT_GEAR_MIN_RATE)) else $error("gear-down at low rate");
    a_row_flag: assert property (@(posedge sys_clk) // [RL10]
        disable iff (!nrst) $rose(row_hot) |-> dval_reg &&
        dcmd_reg == DC_WRITE) else $error("row warning without write");
endmodule

// file: testbench/sot_dev_model.sv
module sot_dev_model (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire sot_pkg::sot_dcmd_t ddr_cmd,
    input  wire logic              ddr_cmd_valid,
    input  wire logic              dqs_out,
    input  wire logic              dqs_oe,
    input  wire logic              ck_phase,
    output logic                   dq
);
    timeunit 1ns;
    timeprecision 1ps;
    import sot_pkg::*;

    // no read path here: the controller never reads, so the earlier
    // read strobe drive of the two-clock preamble never arises
    localparam int WR_LAT = 9; // write latency in clocks, plain default
    logic        lvl_on;
    logic [15:0] wr_pipe;
    int          wr_started;

    // ==================================================
    // internal write start four clocks past write latency; chop is
    // chosen per command, never fixed, so the short case never applies
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pipe    <= 16'h0000;
            wr_started <= 0;
        end else begin
            wr_pipe <= {wr_pipe[14:0], ddr_cmd_valid && ddr_cmd == DC_WRITE};
            if (wr_pipe[WR_LAT + 3]) wr_started <= wr_started + 1;
        end
    end

    // ==================================================
    // leveling mode tracking and feedback of the sampled clock
    // outside a valid sample the line keeps changing, so a stale
    // value can never pass for a result
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lvl_on <= 1'b0;
            dq     <= 1'b0;
        end else begin
            if (ddr_cmd_valid && ddr_cmd == DC_MRS_LVL_ON) begin
                lvl_on <= 1'b1;
            end
            if (ddr_cmd_valid && ddr_cmd == DC_MRS_LVL_OFF) begin
                lvl_on <= 1'b0;
            end
            if (lvl_on && dqs_oe && dqs_out) begin
                dq <= ck_phase;
            end else begin
                dq <= ~dq;
            end
        end
    end
endmodule

// file: testbench/sdram_odt_leveling_timing_test.sv
module sdram_odt_leveling_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sot_pkg::*;

    logic        sys_clk, nrst, cmd_valid, cmd_ready, cmd_chop, pre_2ck;
    logic        parity_en, dll_off, dq_in, ck_phase, ddr_cmd_valid, ddr_odt;
    logic        dqs_out, dqs_oe, level_result, level_valid;
    logic        gear_en, gear_refused, row_hot;
    logic [15:0] cmd_row;
    logic [3:0]  parity_latency, cal_request, cal_setting;
    logic [7:0]  refresh_cycle_time;
    logic [11:0] data_rate, applied_rate;
    sot_op_t     cmd_op;
    sot_dcmd_t   ddr_cmd;
    int          n_fail, comparisons, seed, cyc, t0;
    int          hold_tab[4] = '{4, 5, 6, 7};
    int          rates[6] = '{800, 1599, 1600, 1601, 2400, 3200};
    int          gears[4] = '{2400, 2665, 2666, 3200};

    sot_ctrl sot_ctrl_i (.sys_clk(sys_clk), .nrst(nrst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_chop(cmd_chop), .cmd_row(cmd_row), .pre_2ck(pre_2ck),
        .parity_en(parity_en), .dll_off(dll_off),
        .parity_latency(parity_latency),
        .refresh_cycle_time(refresh_cycle_time), .cal_request(cal_request),
        .data_rate(data_rate), .ddr_cmd(ddr_cmd),
        .ddr_cmd_valid(ddr_cmd_valid), .ddr_odt(ddr_odt), .dqs_out(dqs_out),
        .dqs_oe(dqs_oe), .dq_in(dq_in), .level_result(level_result),
        .level_valid(level_valid), .cal_setting(cal_setting),
        .applied_rate(applied_rate), .gear_en(gear_en),
        .gear_refused(gear_refused), .row_hot(row_hot));
    sot_dev_model sot_dev_model_i (.sys_clk(sys_clk), .nrst(nrst),
        .ddr_cmd(ddr_cmd), .ddr_cmd_valid(ddr_cmd_valid), .dqs_out(dqs_out),
        .dqs_oe(dqs_oe), .ck_phase(ck_phase), .dq(dq_in));

    // ==================================================
    // clock and cycle count
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    // ==================================================
    // shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %0h want %0h", $time, what, got,
                     exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // request held until taken, returns in the first cycle of the answer
    task automatic issue(input sot_op_t op, input logic chop,
                         input logic [15:0] row);
        int n;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_chop = chop;
        cmd_row = row;
        #1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            #1;
            n++;
        end
        check(n < 200, 1'b1, "request never taken");
        @(negedge sys_clk);
        cmd_valid = 1'b0;
    endtask

    // cycles for which termination stays high from now on
    task automatic count_odt(output int c);
        c = 0;
        while (ddr_odt === 1'b1 && c < 20) begin
            c++;
            @(negedge sys_clk);
        end
    endtask

    // strobe pulse age and leveling result over the next five cycles
    task automatic watch(output int at, output logic lr);
        at = -1;
        lr = 1'bx;
        repeat (5) begin
            if (dqs_out === 1'b1 && at < 0) at = cyc - t0;
            if (level_valid === 1'b1) lr = level_result;
            @(negedge sys_clk);
        end
    endtask

    // ==================================================
    // watchdog
    initial begin
        #(40 * 5000);
        n_fail++;
        end_of_test();
    end

    // ==================================================
    // main sequence
    initial begin
        int   c;
        int   at;
        int   rfc;
        int   pl;
        int   cal_min;
        int   rate;
        logic lr;
        logic lng;
        seed = 32'h063c;
        cyc = 0;
        {nrst, cmd_valid, cmd_chop, pre_2ck, parity_en, dll_off} = '0;
        {ck_phase, cmd_row, parity_latency, cal_request} = '0;
        cmd_op = OP_WRITE;
        refresh_cycle_time = 8'h01;
        data_rate = 12'h000;
        repeat (6) @(negedge sys_clk);
        check(cmd_ready, 1'b1, "reset ready");
        check(cal_setting, 4'h3, "reset cal");
        check(applied_rate, 12'd1600, "reset rate");
        check({ddr_cmd_valid, ddr_odt, dqs_oe, dqs_out}, 4'h0, "reset out");
        nrst = 1'b1;
        $display("test reset done");
        // termination hold for every preamble, burst and op kind
        for (int i = 0; i < 8; i++) begin
            pre_2ck = i[0];
            lng = !i[1] && !i[2];
            issue(i[2] ? OP_TERM : OP_WRITE, i[1], 16'($random(seed)));
            if (!i[2]) check({ddr_cmd_valid, ddr_cmd}, {1'b1, DC_WRITE},
                             "write cmd");
            count_odt(c);
            check(c, hold_tab[{lng, i[0]}], "term hold");
        end
        $display("test termination done");
        // refresh wait with every parity and loop setting
        for (int i = 0; i < 4; i++) begin
            parity_en = i[0];
            dll_off = i[1];
            rfc = 1 + ($random(seed) & 15);
            pl = $random(seed) & 15;
            refresh_cycle_time = 8'(rfc);
            parity_latency = 4'(pl);
            issue(OP_REFRESH, 1'b0, 16'h0000);
            check(ddr_cmd, DC_REF, "refresh cmd");
            c = 0;
            while (cmd_ready !== 1'b1 && c < 60) begin
                c++;
                @(negedge sys_clk);
            end
            check(c, rfc + ((i == 3) ? pl : 0), "refresh wait");
        end
        $display("test refresh done");
        // leveling entry, early strobe refused, two samples, exit
        issue(OP_LVL_ON, 1'b0, 16'h0000);
        check({ddr_cmd_valid, ddr_cmd}, {1'b1, DC_MRS_LVL_ON}, "level entry");
        t0 = cyc;
        while (dqs_oe !== 1'b1 && cyc - t0 < 60) @(negedge sys_clk);
        check(cyc - t0 >= 25 && cyc - t0 <= 26, 1'b1, "drive delay");
        issue(OP_STROBE, 1'b0, 16'h0000);
        watch(at, lr);
        check(at < 0, 1'b1, "early strobe");
        while (cyc - t0 < 40) @(negedge sys_clk);
        for (int p = 0; p < 2; p++) begin
            ck_phase = p[0] ? ~ck_phase : 1'($random(seed));
            issue(OP_STROBE, 1'b0, 16'h0000);
            watch(at, lr);
            check(at >= 40, 1'b1, "first strobe age");
            check(lr, ck_phase, "level result");
            check(dqs_oe, 1'b1, "strobe driven");
        end
        issue(OP_LVL_OFF, 1'b0, 16'h0000);
        check(ddr_cmd, DC_MRS_LVL_OFF, "level exit");
        @(negedge sys_clk);
        check(dqs_oe, 1'b0, "strobe release");
        $display("test leveling done");
        // latency floor and rate fallback, table cases then random ones
        cal_min = (3748 + 40000 - 1) / 40000;
        if (cal_min < 3) cal_min = 3;
        for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            cal_request = (i < 4) ? 4'(i) : 4'($random(seed));
            rate = (i < 6) ? rates[i] : ($random(seed) & 12'hfff);
            data_rate = 12'(rate);
            repeat (2) @(negedge sys_clk);
            c = (cal_request > cal_min) ? cal_request : cal_min;
            check(cal_setting, c, "cal setting");
            check(applied_rate, (rate < 1600) ? 1600 : rate, "rate");
        end
        $display("test latency and rate done");
        // half-rate mode only at or above the 2666 MT/s gear-down floor
        for (int i = 0; i < 4; i++) begin
            data_rate = 12'(gears[i]);
            issue(OP_GEAR, 1'b0, 16'h0000);
            check(gear_en, gears[i] >= 2666, "gear enable");
            check(gear_refused, gears[i] < 2666, "gear refused");
        end
        $display("test gear done");
        // same-row warning after eight writes in a row
        pre_2ck = 1'b0;
        rfc = $random(seed) & 16'hfffe;
        for (int i = 0; i < 10; i++) begin
            issue(OP_WRITE, 1'b1, 16'((i == 0 || i == 9) ? rfc : rfc + 1));
            count_odt(c);
            check(row_hot, i == 8, "row warning");
        end
        // four writes earlier plus ten here all reach their internal start
        repeat (16) @(negedge sys_clk);
        check(sot_dev_model_i.wr_started, 14, "internal writes");
        $display("test row spread done");
        end_of_test();
    end
endmodule
